//--- logic/chg_seq_defs.svh
// register indices, field positions, reset values and timing counts of the sequencer
`ifndef CHG_SEQ_DEFS_SVH
`define CHG_SEQ_DEFS_SVH

// ****************************************************************
// register indices (byte address is four times the index)
// ****************************************************************
`define IDX_OPT_LO 6'h00
`define IDX_OPT_HI 6'h01
`define IDX_CHGV_LO 6'h04
`define IDX_CHGV_HI 6'h05
`define IDX_VBUSV_LO 6'h06
`define IDX_VBUSV_HI 6'h07
`define IDX_VBUSI_LO 6'h08
`define IDX_VBUSI_HI 6'h09
`define IDX_MINSYS 6'h0d
`define IDX_IIN_LO 6'h0e
`define IDX_IIN_HI 6'h0f
`define IDX_OPT_MODE 6'h34
`define IDX_OPT_PATH 6'h35
`define IDX_VSYS_TH 6'h36
`define IDX_VAP_ILIM 6'h39
`define IDX_FLOOR 6'h3e
`define IDX_STATUS 6'h3f

// ****************************************************************
// storage slots of the writable registers
// ****************************************************************
`define SLOT_OPT_LO 4'h0
`define SLOT_OPT_HI 4'h1
`define SLOT_CHGV_LO 4'h2
`define SLOT_CHGV_HI 4'h3
`define SLOT_VBUSV_LO 4'h4
`define SLOT_VBUSV_HI 4'h5
`define SLOT_VBUSI_LO 4'h6
`define SLOT_VBUSI_HI 4'h7
`define SLOT_MINSYS 4'h8
`define SLOT_IIN_LO 4'h9
`define SLOT_IIN_HI 4'ha
`define SLOT_OPT_MODE 4'hb
`define SLOT_OPT_PATH 4'hc
`define SLOT_VSYS_TH 4'hd
`define SLOT_VAP_ILIM 4'he
`define NUM_SLOTS 15

// ****************************************************************
// field positions
// ****************************************************************
`define BIT_LOW_POWER 7
`define BIT_REV_FLAG_EN 3
`define BIT_VAP_DIS 5
`define BIT_REV_RANGE 2
`define BIT_HIZ 7
`define BIT_REV_SEL 4

// ****************************************************************
// reset values
// ****************************************************************
`define RST_OPT_HI 8'h80
`define RST_OPT_MODE 8'h20
`define RST_ZERO 8'h00
`define IIN_DEFAULT_CODE 7'h41
`define FLOOR_OFFSET_CODE 8'h14

// ****************************************************************
// timing
// ****************************************************************
`define CLK_FREQ_KHZ 125000
`define QUAL_MS 50
`define START_MS 150
`define RETRY_S 2
`define REV_MS 10
`define QUAL_CYCLES (`QUAL_MS * `CLK_FREQ_KHZ)
`define START_CYCLES (`START_MS * `CLK_FREQ_KHZ)
`define RETRY_CYCLES (`RETRY_S * 1000 * `CLK_FREQ_KHZ)
`define REV_CYCLES (`REV_MS * `CLK_FREQ_KHZ)

`endif

//--- logic/chg_seq_pkg.sv
// types shared by the charger power mode sequencer
package chg_seq_pkg;

  // forward power-up states, gray coded in declaration order
  typedef enum logic [2:0] {
    FWD_IDLE = 3'h0,
    FWD_QUAL = 3'h1,
    FWD_RETRY = 3'h3,
    FWD_SETUP = 3'h2,
    FWD_RUN = 3'h6
  } fwd_state_e;

  // converter topology in use
  typedef enum logic [1:0] {
    CONV_BUCK = 2'h0,
    CONV_BUCK_BOOST = 2'h1,
    CONV_BOOST = 2'h3
  } conv_mode_e;

  // comparator and pin levels from the analog side, all asynchronous
  typedef struct packed {
    logic vbus_above_uvloz;
    logic vbus_above_conven;
    logic vbus_below_convenz;
    logic vbus_above_acov;
    logic bat_above_uvlo;
    logic fault;
    logic bat_ovp;
    logic reverse_enable_pin;
    logic highz_pin_low;
    logic vin_well_above;
    logic vin_well_below;
  } pins_s;

endpackage

//--- logic/charger_power_mode_sequencer.sv
// power mode sequencer of the buck-boost charger, with its apb register file
//
// Implementation choices: the register addresses and register access over APB.
`timescale 1ns/1ps
`include "chg_seq_defs.svh"

module charger_power_mode_sequencer #(
  parameter logic [27:0] QUAL_CYCLES = 28'(`QUAL_CYCLES),
  parameter logic [27:0] START_CYCLES = 28'(`START_CYCLES),
  parameter logic [27:0] RETRY_CYCLES = 28'(`RETRY_CYCLES),
  parameter logic [27:0] REV_CYCLES = 28'(`REV_CYCLES)
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire chg_seq_pkg::pins_s pins,
  input wire logic [7:0] vbus_adc_code,
  input wire logic [6:0] ilim_pin_code,
  input wire logic [1:0] cell_sense_level,
  input wire logic adapter_good_flag_in,
  output logic adapter_good_flag_out,
  output logic adapter_good_flag_oe,
  output logic battery_switch_on,
  output logic low_power_mode,
  output logic gate_drive_regulator_en,
  output logic internal_analog_regulator_en,
  output logic converter_on,
  output chg_seq_pkg::conv_mode_e converter_mode,
  output logic capacitor_boost_protection,
  output logic [15:0] vap_vbus_target,
  output logic [15:0] vap_current_limit,
  output logic [5:0] vap_current_limit_fine,
  output logic [5:0] min_system_voltage,
  output logic [3:0] vsys_th1_code,
  output logic [1:0] vsys_th2_code,
  output logic [6:0] input_current_limit,
  output logic [7:0] input_voltage_floor,
  output logic [1:0] cell_count,
  output logic highz_active,
  output logic reverse_active,
  output logic [15:0] reverse_output_voltage,
  output logic reverse_offset_1280mv
);

  // ****************************************************************
  // helper functions
  // ****************************************************************

  // register index to {mapped, slot}
  function automatic logic [4:0] slot_of(input logic [5:0] idx);
    case (idx)
      `IDX_OPT_LO: slot_of = {1'b1, `SLOT_OPT_LO};
      `IDX_OPT_HI: slot_of = {1'b1, `SLOT_OPT_HI};
      `IDX_CHGV_LO: slot_of = {1'b1, `SLOT_CHGV_LO};
      `IDX_CHGV_HI: slot_of = {1'b1, `SLOT_CHGV_HI};
      `IDX_VBUSV_LO: slot_of = {1'b1, `SLOT_VBUSV_LO};
      `IDX_VBUSV_HI: slot_of = {1'b1, `SLOT_VBUSV_HI};
      `IDX_VBUSI_LO: slot_of = {1'b1, `SLOT_VBUSI_LO};
      `IDX_VBUSI_HI: slot_of = {1'b1, `SLOT_VBUSI_HI};
      `IDX_MINSYS: slot_of = {1'b1, `SLOT_MINSYS};
      `IDX_IIN_LO: slot_of = {1'b1, `SLOT_IIN_LO};
      `IDX_IIN_HI: slot_of = {1'b1, `SLOT_IIN_HI};
      `IDX_OPT_MODE: slot_of = {1'b1, `SLOT_OPT_MODE};
      `IDX_OPT_PATH: slot_of = {1'b1, `SLOT_OPT_PATH};
      `IDX_VSYS_TH: slot_of = {1'b1, `SLOT_VSYS_TH};
      `IDX_VAP_ILIM: slot_of = {1'b1, `SLOT_VAP_ILIM};
      default: slot_of = {1'b0, 4'h0};
    endcase
  endfunction

  // reset value of each slot; a constant for a constant slot
  function automatic logic [7:0] rst_of(input int slot);
    if (slot == int'(`SLOT_OPT_HI))
    begin
      rst_of = `RST_OPT_HI;
    end
    else if (slot == int'(`SLOT_OPT_MODE))
    begin
      rst_of = `RST_OPT_MODE;
    end
    else
    begin
      rst_of = `RST_ZERO;
    end
  endfunction

  // ****************************************************************
  // pin synchronisers
  // ****************************************************************

  logic [$bits(chg_seq_pkg::pins_s)-1:0] sy1_q; // first stage, read by sy2 only
  logic [$bits(chg_seq_pkg::pins_s)-1:0] sy2_q;
  logic [$bits(chg_seq_pkg::pins_s)-1:0] sy3_q;
  logic [$bits(chg_seq_pkg::pins_s)-1:0] pin_lvl_q; // accepted levels
  logic [$bits(chg_seq_pkg::pins_s)-1:0] pin_lvl_d;
  chg_seq_pkg::pins_s pin; // accepted levels, by name

  // a level is taken only once stage two and three agree
  always_comb
  begin
    pin_lvl_d = (sy2_q & sy3_q) | (pin_lvl_q & (sy2_q | sy3_q));
  end

  // three-stage chain plus accepted level
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sy1_q <= '0;
      sy2_q <= '0;
      sy3_q <= '0;
      pin_lvl_q <= '0;
    end
    else
    begin
      sy1_q <= pins;
      sy2_q <= sy1_q;
      sy3_q <= sy2_q;
      pin_lvl_q <= pin_lvl_d;
    end
  end

  assign pin = pin_lvl_q;

  // ****************************************************************
  // apb register file
  // ****************************************************************

  logic [7:0] regs_q [`NUM_SLOTS]; // writable registers
  logic [7:0] regs_d [`NUM_SLOTS];
  logic [31:0] prdata_q; // read data, captured in the setup cycle
  logic [31:0] prdata_d;
  logic [4:0] hit; // {mapped, slot} of the current address
  logic misaligned;
  logic ro_hit; // floor or status index
  logic wr_en; // write takes effect this edge
  logic [7:0] status_byte;
  logic vap_q; // protection mode active
  logic ag_q; // adapter good flag
  logic ag_fwd_rise; // forward flag just rose
  logic [7:0] floor_q;

  assign hit = slot_of(paddr[7:2]);
  assign misaligned = paddr[1:0] != 2'h0;
  assign ro_hit = (paddr[7:2] == `IDX_FLOOR) || (paddr[7:2] == `IDX_STATUS);
  // zero wait states: every access phase completes at once
  assign pready = 1'b1;
  // unmapped or misaligned addresses answer with an error
  assign pslverr = psel && penable && (misaligned || !(hit[4] || ro_hit));
  assign wr_en = psel && penable && pwrite && !misaligned && hit[4];
  assign prdata = prdata_q;

  // read mux and register next values
  always_comb
  begin
    prdata_d = prdata_q;
    if (psel && !penable && !pwrite)
    begin
      prdata_d = 32'h0;
      if (misaligned)
      begin
        prdata_d = 32'h0;
      end
      else if (hit[4])
      begin
        prdata_d = {24'h0, regs_q[hit[3:0]]};
      end
      else if (paddr[7:2] == `IDX_FLOOR)
      begin
        prdata_d = {24'h0, floor_q};
      end
      else if (paddr[7:2] == `IDX_STATUS)
      begin
        prdata_d = {24'h0, status_byte};
      end
    end
    for (int i = 0; i < `NUM_SLOTS; i++)
    begin
      regs_d[i] = regs_q[i];
    end
    if (wr_en)
    begin
      regs_d[hit[3:0]] = pwdata[7:0];
    end
    // default input limit once the adapter flag rises
    if (ag_fwd_rise)
    begin
      regs_d[`SLOT_IIN_LO] = 8'h00;
      regs_d[`SLOT_IIN_HI] = {1'b0, `IIN_DEFAULT_CODE};
    end
    // a fault in protection mode sets the disable bit; beats a write clearing it
    if (vap_q && pin.fault)
    begin
      regs_d[`SLOT_OPT_MODE][`BIT_VAP_DIS] = 1'b1;
    end
  end

  // register file and read data flops
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      for (int i = 0; i < `NUM_SLOTS; i++)
      begin
        regs_q[i] <= rst_of(i);
      end
      prdata_q <= 32'h0;
    end
    else
    begin
      regs_q <= regs_d;
      prdata_q <= prdata_d;
    end
  end

  // ****************************************************************
  // forward power-up from an input source
  // ****************************************************************

  chg_seq_pkg::fwd_state_e fwd_q;
  chg_seq_pkg::fwd_state_e fwd_d;
  logic [27:0] fwd_cnt_q; // qualification and retry timer
  logic [27:0] fwd_cnt_d;
  logic [27:0] conven_cnt_q; // time above enable threshold, saturating
  logic [27:0] conven_cnt_d;
  logic [1:0] cell_q;
  logic [1:0] cell_d;
  logic [7:0] floor_d;
  logic [6:0] ilim_q;
  logic [6:0] ilim_d;
  logic highz;
  logic ldo_on; // regulator and internal bias up

  assign highz = pin.highz_pin_low || regs_q[`SLOT_OPT_PATH][`BIT_HIZ];
  assign ldo_on = (fwd_q == chg_seq_pkg::FWD_SETUP) || (fwd_q == chg_seq_pkg::FWD_RUN);

  // plug-in sequence next state
  always_comb
  begin
    fwd_d = fwd_q;
    fwd_cnt_d = fwd_cnt_q;
    conven_cnt_d = conven_cnt_q;
    cell_d = cell_q;
    floor_d = floor_q;
    // time spent continuously above the enable threshold
    if (!pin.vbus_above_conven)
    begin
      conven_cnt_d = 28'h0;
    end
    else if (conven_cnt_q != START_CYCLES - 28'h1)
    begin
      conven_cnt_d = conven_cnt_q + 28'h1;
    end
    unique case (fwd_q)
      chg_seq_pkg::FWD_IDLE:
      begin
        fwd_cnt_d = 28'h0;
        if (pin.vbus_above_uvloz)
        begin
          fwd_d = chg_seq_pkg::FWD_QUAL;
        end
      end
      chg_seq_pkg::FWD_QUAL:
      begin
        if (!pin.vbus_above_uvloz)
        begin
          fwd_d = chg_seq_pkg::FWD_IDLE;
        end
        else if (fwd_cnt_q != QUAL_CYCLES - 28'h1)
        begin
          fwd_cnt_d = fwd_cnt_q + 28'h1;
        end
        else if (!pin.vbus_above_conven)
        begin
          fwd_cnt_d = 28'h0;
          fwd_d = chg_seq_pkg::FWD_RETRY;
        end
        else if (conven_cnt_q >= QUAL_CYCLES - 28'h1)
        begin
          fwd_d = chg_seq_pkg::FWD_SETUP;
        end
      end
      chg_seq_pkg::FWD_RETRY:
      begin
        if (!pin.vbus_above_uvloz)
        begin
          fwd_d = chg_seq_pkg::FWD_IDLE;
        end
        else if (fwd_cnt_q != RETRY_CYCLES - 28'h1)
        begin
          fwd_cnt_d = fwd_cnt_q + 28'h1;
        end
        else
        begin
          // re-check; qualify again only after the 50 ms enable window
          fwd_cnt_d = 28'h0;
          if (pin.vbus_above_conven)
          begin
            fwd_cnt_d = QUAL_CYCLES - 28'h1;
            fwd_d = chg_seq_pkg::FWD_QUAL;
          end
        end
      end
      chg_seq_pkg::FWD_SETUP:
      begin
        cell_d = cell_sense_level;
        if (!pin.vbus_above_conven)
        begin
          fwd_d = chg_seq_pkg::FWD_IDLE;
        end
        else if (conven_cnt_q == START_CYCLES - 28'h1 && !highz)
        begin
          // unloaded input taken just before the converter starts
          floor_d = (vbus_adc_code > `FLOOR_OFFSET_CODE) ?
                    vbus_adc_code - `FLOOR_OFFSET_CODE : 8'h00;
          fwd_d = chg_seq_pkg::FWD_RUN;
        end
      end
      chg_seq_pkg::FWD_RUN:
      begin
        if (!pin.vbus_above_conven)
        begin
          fwd_d = chg_seq_pkg::FWD_IDLE;
        end
      end
      default:
      begin
        fwd_d = chg_seq_pkg::FWD_IDLE;
      end
    endcase
    // lower of register and pin setting
    ilim_d = (regs_q[`SLOT_IIN_HI][6:0] < ilim_pin_code) ?
             regs_q[`SLOT_IIN_HI][6:0] : ilim_pin_code;
  end

  // plug-in sequence flops
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      fwd_q <= chg_seq_pkg::FWD_IDLE;
      fwd_cnt_q <= 28'h0;
      conven_cnt_q <= 28'h0;
      cell_q <= 2'h0;
      floor_q <= 8'h00;
      ilim_q <= 7'h00;
    end
    else
    begin
      fwd_q <= fwd_d;
      fwd_cnt_q <= fwd_cnt_d;
      conven_cnt_q <= conven_cnt_d;
      cell_q <= cell_d;
      floor_q <= floor_d;
      ilim_q <= ilim_d;
    end
  end

  // ****************************************************************
  // battery-only modes: protection and reverse output
  // ****************************************************************

  logic vap_d;
  logic rev_cond; // all reverse enable conditions
  logic [27:0] rev_cnt_q; // time the conditions have held
  logic [27:0] rev_cnt_d;
  logic rev_q;
  logic rev_d;
  logic ag_d;
  logic ag_fwd; // forward part of the good flag
  logic conv_q;
  logic conv_d;
  chg_seq_pkg::conv_mode_e mode_q;
  chg_seq_pkg::conv_mode_e mode_d;

  assign rev_cond = pin.reverse_enable_pin
                 && regs_q[`SLOT_OPT_PATH][`BIT_REV_SEL]
                 && regs_q[`SLOT_OPT_MODE][`BIT_VAP_DIS]
                 && pin.vbus_below_convenz;
  assign ag_fwd = ldo_on && pin.vbus_above_conven && !pin.vbus_above_acov
               && !pin.fault;
  assign ag_fwd_rise = ag_fwd && !ag_q && !rev_q;

  // mode next values
  always_comb
  begin
    // both bits clear and pin high; a fault or a set bit ends it
    vap_d = !regs_q[`SLOT_OPT_MODE][`BIT_VAP_DIS]
         && !regs_q[`SLOT_OPT_PATH][`BIT_REV_SEL]
         && pin.reverse_enable_pin && !pin.fault && !rev_q;
    rev_cnt_d = 28'h0;
    rev_d = 1'b0;
    if (rev_cond)
    begin
      rev_cnt_d = rev_cnt_q;
      if (rev_cnt_q != REV_CYCLES - 28'h1)
      begin
        rev_cnt_d = rev_cnt_q + 28'h1;
      end
      else
      begin
        rev_d = 1'b1;
      end
    end
    // good flag: forward conditions, or reverse when allowed
    ag_d = ag_fwd || (rev_d && regs_q[`SLOT_OPT_HI][`BIT_REV_FLAG_EN]);
    // switching: forward run outside high impedance, protection, or reverse without overvoltage
    conv_d = ((fwd_q == chg_seq_pkg::FWD_RUN) && !highz) || vap_d
          || (rev_d && !pin.bat_ovp);
    // topology follows the input to output ratio, converter keeps running
    if (pin.vin_well_above)
    begin
      mode_d = chg_seq_pkg::CONV_BUCK;
    end
    else if (pin.vin_well_below)
    begin
      mode_d = chg_seq_pkg::CONV_BOOST;
    end
    else
    begin
      mode_d = chg_seq_pkg::CONV_BUCK_BOOST;
    end
  end

  // mode flops
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      vap_q <= 1'b0;
      rev_cnt_q <= 28'h0;
      rev_q <= 1'b0;
      ag_q <= 1'b0;
      conv_q <= 1'b0;
      mode_q <= chg_seq_pkg::CONV_BUCK_BOOST;
    end
    else
    begin
      vap_q <= vap_d;
      rev_cnt_q <= rev_cnt_d;
      rev_q <= rev_d;
      ag_q <= ag_d;
      conv_q <= conv_d;
      mode_q <= mode_d;
    end
  end

  // ****************************************************************
  // outputs
  // ****************************************************************

  assign status_byte = {cell_q, regs_q[`SLOT_OPT_HI][`BIT_LOW_POWER], highz, rev_q, vap_q,
                        conv_q, ag_q};
  // open drain: pull low whenever the flag is not good
  assign adapter_good_flag_out = 1'b0;
  assign adapter_good_flag_oe = !ag_q;
  assign battery_switch_on = pin.bat_above_uvlo;
  assign low_power_mode = regs_q[`SLOT_OPT_HI][`BIT_LOW_POWER];
  // performance mode, high impedance and any powered state keep it on
  assign gate_drive_regulator_en = !regs_q[`SLOT_OPT_HI][`BIT_LOW_POWER] || highz
                                || ldo_on || vap_q || rev_q;
  assign internal_analog_regulator_en = ldo_on;
  assign converter_on = conv_q;
  assign converter_mode = mode_q;
  assign capacitor_boost_protection = vap_q;
  assign vap_vbus_target = {regs_q[`SLOT_VBUSV_HI], regs_q[`SLOT_VBUSV_LO]};
  assign vap_current_limit = {regs_q[`SLOT_VBUSI_HI], regs_q[`SLOT_VBUSI_LO]};
  assign vap_current_limit_fine = regs_q[`SLOT_VAP_ILIM][7:2];
  assign min_system_voltage = regs_q[`SLOT_MINSYS][5:0];
  assign vsys_th1_code = regs_q[`SLOT_VSYS_TH][7:4];
  assign vsys_th2_code = regs_q[`SLOT_VSYS_TH][3:2];
  assign input_current_limit = ilim_q;
  assign input_voltage_floor = floor_q;
  assign cell_count = cell_q;
  assign highz_active = highz;
  assign reverse_active = rev_q;
  assign reverse_output_voltage = {regs_q[`SLOT_VBUSV_HI], regs_q[`SLOT_VBUSV_LO]};
  // range bit clear means the code sits 1.28 V higher
  assign reverse_offset_1280mv = !regs_q[`SLOT_OPT_MODE][`BIT_REV_RANGE];

endmodule // charger_power_mode_sequencer

//--- testbench/chg_seq_props.sv
// concurrent property checker for the charger power mode sequencer
`timescale 1ns/1ps
module chg_seq_props (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [6:0] ilim_pin_code,
  input wire logic adapter_good_flag_out,
  input wire logic low_power_mode,
  input wire logic gate_drive_regulator_en,
  input wire logic capacitor_boost_protection,
  input wire logic [5:0] min_system_voltage,
  input wire logic [3:0] vsys_th1_code,
  input wire logic [1:0] vsys_th2_code,
  input wire logic [6:0] input_current_limit,
  input wire logic highz_active,
  input wire logic reverse_active,
  input wire logic converter_on,
  input wire logic reverse_offset_1280mv
);
  // ****************************************************************
  // one clock domain, so one default clocking
  // ****************************************************************
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic acc; // access phase of an apb transfer
  assign acc = psel && penable;
  a_zero_wait: assert property (acc |-> pready) else $error("pready low in access");
  a_unmapped_err: assert property (acc && paddr == 8'h08 |-> pslverr) else $error("no error");
  a_perf_gate: assert property (!low_power_mode |-> gate_drive_regulator_en)
    else $error("gate drive off in performance mode");
  a_highz_gate: assert property (highz_active |-> gate_drive_regulator_en)
    else $error("gate drive off in high impedance");
  a_mode_excl: assert property (!(capacitor_boost_protection && reverse_active))
    else $error("both modes at once");
  a_flag_od: assert property (adapter_good_flag_out == 1'b0)
    else $error("open drain flag driven high");
  a_th_track: assert property (acc && pwrite && paddr == 8'hd8 |=>
    {vsys_th1_code, vsys_th2_code} == $past(pwdata[7:2])) else $error("thresholds wrong");
  a_minsys_track: assert property (acc && pwrite && paddr == 8'h34 |=>
    min_system_voltage == $past(pwdata[5:0])) else $error("min system wrong");
  a_offset_sel: assert property (acc && pwrite && paddr == 8'hd0 |=>
    reverse_offset_1280mv == !$past(pwdata[2])) else $error("offset select wrong");
  a_ilim_lower: assert property (input_current_limit <= $past(ilim_pin_code))
    else $error("limit above pin setting");
  c_vap: cover property (capacitor_boost_protection);
  c_rev: cover property (reverse_active);
  c_conv: cover property ($rose(converter_on));
endmodule // chg_seq_props

bind charger_power_mode_sequencer chg_seq_props u_props (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .pready(pready), .pslverr(pslverr), .ilim_pin_code(ilim_pin_code),
  .adapter_good_flag_out(adapter_good_flag_out), .low_power_mode(low_power_mode),
  .gate_drive_regulator_en(gate_drive_regulator_en),
  .capacitor_boost_protection(capacitor_boost_protection),
  .min_system_voltage(min_system_voltage), .vsys_th1_code(vsys_th1_code),
  .vsys_th2_code(vsys_th2_code), .input_current_limit(input_current_limit),
  .highz_active(highz_active), .reverse_active(reverse_active), .converter_on(converter_on),
  .reverse_offset_1280mv(reverse_offset_1280mv));

//--- testbench/host_pin_model.sv
// behavioural model of the host pins and analog comparators
`timescale 1ns/1ps
module host_pin_model (
  input wire logic pclk,
  input wire logic [1:0] vbus_lvl,
  input wire logic bat_ok,
  input wire logic fault_in,
  input wire logic rev_pin,
  input wire logic hz_pin,
  input wire logic bat_ovp_in,
  output chg_seq_pkg::pins_s pins
);
  // levels known from time zero so the synchronisers never see unknowns
  initial pins = '0;
  // vbus_lvl: 0 absent, 1 above release only, 2 above converter enable
  always @(posedge pclk)
  begin
    pins <= '{vbus_above_uvloz: vbus_lvl != 2'h0, vbus_above_conven: vbus_lvl == 2'h2,
      vbus_below_convenz: vbus_lvl == 2'h0, vbus_above_acov: 1'b0, bat_above_uvlo: bat_ok,
      fault: fault_in, bat_ovp: bat_ovp_in, reverse_enable_pin: rev_pin,
      highz_pin_low: hz_pin, vin_well_above: vbus_lvl == 2'h2, vin_well_below: vbus_lvl == 2'h1};
  end
endmodule // host_pin_model

//--- testbench/charger_power_mode_sequencer_tb_top.sv
// self-checking bench of the charger power mode sequencer
`timescale 1ns/1ps
module charger_power_mode_sequencer_tb_top;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [7:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rd_data;
  logic pready, pslverr, rd_err, oe, hz = 0, bat = 0, flt = 0, rev = 0, ovp = 0;
  logic [1:0] lvl = '0;
  chg_seq_pkg::pins_s pins;
  int fail_count = 0, checks_done = 0, cyc = 0;
  logic ao, lp, gd, ia, co, cbp, hza, ra, ro, bs;
  logic [15:0] vt;
  logic [5:0] ms;
  logic [3:0] t1;
  logic [1:0] t2;
  logic [6:0] icl;
  logic [6:0] ipc = 7'h7f; // limit pin setting, driven so the lower-of rule is exercised
  logic [7:0] flr;
  initial forever #4 pclk = ~pclk;
  // short counts keep the run small
  charger_power_mode_sequencer #(.QUAL_CYCLES(28'h14), .START_CYCLES(28'h3c),
    .RETRY_CYCLES(28'h64), .REV_CYCLES(28'ha)) dut (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .pins(pins),
    .vbus_adc_code(8'h50), .ilim_pin_code(ipc), .cell_sense_level(2'h2),
    .adapter_good_flag_in(!oe), .adapter_good_flag_out(ao), .adapter_good_flag_oe(oe),
    .battery_switch_on(bs), .low_power_mode(lp), .gate_drive_regulator_en(gd),
    .internal_analog_regulator_en(ia), .converter_on(co), .converter_mode(),
    .capacitor_boost_protection(cbp), .vap_vbus_target(vt), .vap_current_limit(),
    .vap_current_limit_fine(), .min_system_voltage(ms), .vsys_th1_code(t1),
    .vsys_th2_code(t2), .input_current_limit(icl), .input_voltage_floor(flr),
    .cell_count(), .highz_active(hza), .reverse_active(ra), .reverse_output_voltage(),
    .reverse_offset_1280mv(ro));
  host_pin_model u_host (.pclk(pclk), .vbus_lvl(lvl), .bat_ok(bat), .fault_in(flt),
    .rev_pin(rev), .hz_pin(hz), .bat_ovp_in(ovp), .pins(pins));
  // ****************************************************************
  // apb master and comparison helpers
  // ****************************************************************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      fail_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // one transfer; waits on pready, so it holds up for wait states too
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd_data = prdata;
    rd_err = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    xfer(1'b0, a, '0);
    chk(rd_data, exp);
  endtask
  task automatic results;
    if (fail_count == 0 && checks_done > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // hang guard: whole sequence is well under this
  always @(posedge pclk)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      fail_count++;
      results();
    end
  end
  // ****************************************************************
  // scenarios
  // ****************************************************************
  initial
  begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    rdc(8'h04, 32'h80); chk(lp, 1'b1);
    rdc(8'hd0, 32'h20);
    rdc(8'h08, 32'h0); chk(rd_err, 1'b1);
    bat <= 1'b1; repeat (6) @(posedge pclk); chk(bs, 1'b1);
    xfer(1'b1, 8'h04, 32'h0); @(posedge pclk); chk({lp, gd}, 2'b01);
    xfer(1'b1, 8'hd8, 32'ha4); @(posedge pclk); chk({t1, t2}, 6'h29);
    xfer(1'b1, 8'h34, 32'h3f); @(posedge pclk); chk(ms, 6'h3f);
    xfer(1'b1, 8'h1c, 32'h12); xfer(1'b1, 8'h18, 32'h34); @(posedge pclk);
    chk(vt, 16'h1234);
    xfer(1'b1, 8'hd0, 32'h0); xfer(1'b1, 8'hd4, 32'h0);
    // pin path is five edges, the registered mode one more
    rev <= 1'b1; repeat (7) @(posedge pclk); chk(cbp, 1'b1);
    rev <= 1'b0; repeat (7) @(posedge pclk); chk(cbp, 1'b0);
    rev <= 1'b1; repeat (7) @(posedge pclk); chk(cbp, 1'b1);
    flt <= 1'b1; repeat (7) @(posedge pclk); chk(cbp, 1'b0);
    rdc(8'hd0, 32'h20); flt <= 1'b0;
    xfer(1'b1, 8'hd0, 32'h20); xfer(1'b1, 8'hd4, 32'h10); @(posedge pclk);
    chk(ro, 1'b1);
    repeat (4) @(posedge pclk); chk(ra, 1'b0);
    repeat (16) @(posedge pclk); chk({ra, cbp, oe}, 3'b101);
    chk(co, 1'b1);
    ovp <= 1'b1; repeat (7) @(posedge pclk); chk(co, 1'b0); ovp <= 1'b0;
    xfer(1'b1, 8'hd0, 32'h24); @(posedge pclk); chk(ro, 1'b0);
    rev <= 1'b0; xfer(1'b1, 8'hd4, 32'h80); @(posedge pclk); chk({hza, gd}, 2'b11);
    xfer(1'b1, 8'hd4, 32'h0); hz <= 1'b1; repeat (6) @(posedge pclk);
    chk(hza, 1'b1); hz <= 1'b0;
    lvl <= 2'h2; repeat (12) @(posedge pclk); chk(oe, 1'b1);
    repeat (20) @(posedge pclk); chk({oe, co, ia}, 3'b001);
    chk(icl, 7'h41);
    ipc <= 7'h20; repeat (2) @(posedge pclk); chk(icl, 7'h20);
    repeat (40) @(posedge pclk); chk(co, 1'b1); chk(flr, 8'h3c);
    rdc(8'hf8, 32'h3c);
    flt <= 1'b1; repeat (7) @(posedge pclk); chk(oe, 1'b1);
    results();
  end
endmodule // charger_power_mode_sequencer_tb_top
